// file: video_sync_gpio_direction_map.svh
`ifndef VIDEO_SYNC_GPIO_DIRECTION_MAP_SVH
`define VIDEO_SYNC_GPIO_DIRECTION_MAP_SVH

// Register offsets (byte addresses)
`define VIDEO_BUS_DIR_OFFSET 12'h06C
`define SYNC_PIN_DIR_OFFSET 12'h070
`define VIDEO_BUS_OUT_OFFSET 12'h100
`define SYNC_PIN_OUT_OFFSET 12'h104
`define VIDEO_BUS_IN_OFFSET 12'h108
`define SYNC_PIN_IN_OFFSET 12'h10C

// Field positions in the video bus registers
`define VIDEO_OUT_MSB 31
`define VIDEO_OUT_LSB 8
`define VIDEO_IN_MSB 7
`define VIDEO_IN_LSB 0

// Field positions in the sync registers
`define SYNC_MSB 5
`define SYNC_LSB 0
`define DISP_OUT_VSYNC_BIT 5
`define DISP_OUT_HSYNC_BIT 4
`define ANALOG_VSYNC_BIT 3
`define ANALOG_HSYNC_BIT 2
`define CAPTURE_VSYNC_BIT 1
`define CAPTURE_HSYNC_BIT 0

// Reset values
`define VIDEO_OUT_RESET 24'h000000
`define VIDEO_IN_RESET 8'h00
`define SYNC_RESET 6'h00
`define READ_IDLE 32'h00000000

`endif

// file: video_sync_gpio_pkg.sv
package video_sync_gpio_pkg;

   typedef logic [31:0] word_t;

   // One bit per borrowed pin, grouped as on the package
   typedef struct packed {
      logic [23:0] video_out_bus;
      logic [7:0] video_in_bus;
      logic [5:0] sync;
   } pin_group_s;

endpackage

// file: pin_synchronizer.sv
`timescale 1ns/1ps

module pin_synchronizer #(
   parameter int WIDTH = 38
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage_one;

   // First stage feeds only the second stage
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         stage_one <= '0;
         sync_out <= '0;
      end else begin
         stage_one <= async_in;
         sync_out <= stage_one;
      end
   end

endmodule

// file: video_sync_gpio_direction.sv
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "video_sync_gpio_direction_map.svh"

//////////////////////////////////////////////////////////////////////////////////////////////////
// Contract
// - Bits 31:8 of the video bus direction register hold a read/write direction bit per video output bus pin, reset to zero.
// - A video output bus pin in GPIO use with direction zero is an input and is not driven.
// - A video output bus pin in GPIO use with direction one is driven as a general purpose output.
// - A video output bus direction bit has no effect while its pin is not in GPIO use, but still stores its value.
// - Bits 7:0 hold a read/write direction bit per video input bus pin, reset to zero, zero input and one output.
// - A video input bus direction bit is ignored while its pin is not in GPIO use.
// - Sync register bit 5 sets the display output vertical sync pin direction, reset to zero.
// - Sync register bit 4 sets the display output horizontal sync pin direction, reset to zero.
// - Sync register bit 3 sets the analog display vertical sync pin direction, reset to zero.
// - Sync register bit 2 sets the analog display horizontal sync pin direction.
// - Sync register bit 1 sets the capture vertical sync pin direction, reset to zero.
// - Sync register bit 0 sets the capture horizontal sync pin direction, reset to zero.
// - Each sync direction bit is disregarded while its pin is not in GPIO use, leaving the normal function.
module video_sync_gpio_direction
   import video_sync_gpio_pkg::*;
#(
   parameter int ADDR_WIDTH = 12
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [ADDR_WIDTH-1:0] addr,
   input wire word_t wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output word_t rd_data,
   input wire pin_group_s gpio_select,
   input wire pin_group_s func_out,
   input wire pin_group_s func_oe,
   input wire pin_group_s pin_in,
   output pin_group_s pin_out,
   output pin_group_s pin_oe
);

   //////////////////////////////////////////////////////////////////////////////////////////////
   // Address decode

   function automatic logic reg_hit(input logic [ADDR_WIDTH-1:0] a, input logic [11:0] offset);
      reg_hit = (a == ADDR_WIDTH'(offset));
   endfunction

   wire hit_vbus_dir = reg_hit(addr, `VIDEO_BUS_DIR_OFFSET);
   wire hit_sync_dir = reg_hit(addr, `SYNC_PIN_DIR_OFFSET);
   wire hit_vbus_out = reg_hit(addr, `VIDEO_BUS_OUT_OFFSET);
   wire hit_sync_out = reg_hit(addr, `SYNC_PIN_OUT_OFFSET);
   wire hit_vbus_in = reg_hit(addr, `VIDEO_BUS_IN_OFFSET);
   wire hit_sync_in = reg_hit(addr, `SYNC_PIN_IN_OFFSET);

   //////////////////////////////////////////////////////////////////////////////////////////////
   // Software registers

   logic [23:0] video_out_dir;
   logic [7:0] video_in_dir;
   logic [5:0] sync_dir;
   logic [23:0] video_out_data;
   logic [7:0] video_in_data;
   logic [5:0] sync_data;

   // Stored regardless of function select
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         video_out_dir <= `VIDEO_OUT_RESET;
         video_in_dir <= `VIDEO_IN_RESET;
      end else if (wr_en && hit_vbus_dir) begin
         video_out_dir <= wr_data[`VIDEO_OUT_MSB:`VIDEO_OUT_LSB];
         video_in_dir <= wr_data[`VIDEO_IN_MSB:`VIDEO_IN_LSB];
      end
   end

   // Upper bits are not stored at all
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sync_dir <= `SYNC_RESET;
      end else if (wr_en && hit_sync_dir) begin
         sync_dir <= wr_data[`SYNC_MSB:`SYNC_LSB];
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         video_out_data <= `VIDEO_OUT_RESET;
         video_in_data <= `VIDEO_IN_RESET;
      end else if (wr_en && hit_vbus_out) begin
         video_out_data <= wr_data[`VIDEO_OUT_MSB:`VIDEO_OUT_LSB];
         video_in_data <= wr_data[`VIDEO_IN_MSB:`VIDEO_IN_LSB];
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sync_data <= `SYNC_RESET;
      end else if (wr_en && hit_sync_out) begin
         sync_data <= wr_data[`SYNC_MSB:`SYNC_LSB];
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////////////
   // Per-pin direction

   wire disp_out_vsync_dir = sync_dir[`DISP_OUT_VSYNC_BIT];
   wire disp_out_hsync_dir = sync_dir[`DISP_OUT_HSYNC_BIT];
   wire analog_vsync_dir = sync_dir[`ANALOG_VSYNC_BIT];
   wire analog_hsync_dir = sync_dir[`ANALOG_HSYNC_BIT];
   wire capture_vsync_dir = sync_dir[`CAPTURE_VSYNC_BIT];
   wire capture_hsync_dir = sync_dir[`CAPTURE_HSYNC_BIT];

   wire [5:0] sync_dir_pins = {disp_out_vsync_dir, disp_out_hsync_dir, analog_vsync_dir,
                               analog_hsync_dir, capture_vsync_dir, capture_hsync_dir};

   pin_group_s gpio_dir;
   pin_group_s gpio_data;
   assign gpio_dir = '{video_out_bus: video_out_dir, video_in_bus: video_in_dir,
                       sync: sync_dir_pins};
   assign gpio_data = '{video_out_bus: video_out_data, video_in_bus: video_in_data,
                        sync: sync_data};

   //////////////////////////////////////////////////////////////////////////////////////////////
   // Pin muxing

   // Unselected pins stay with their normal function; direction bits are ignored there
   pin_group_s next_pin_oe;
   pin_group_s next_pin_out;
   assign next_pin_oe.video_out_bus = (gpio_select.video_out_bus & gpio_dir.video_out_bus)
      | (~gpio_select.video_out_bus & func_oe.video_out_bus);
   assign next_pin_oe.video_in_bus = (gpio_select.video_in_bus & gpio_dir.video_in_bus)
      | (~gpio_select.video_in_bus & func_oe.video_in_bus);
   assign next_pin_oe.sync = (gpio_select.sync & gpio_dir.sync)
      | (~gpio_select.sync & func_oe.sync);
   assign next_pin_out = (gpio_select & gpio_data) | (~gpio_select & func_out);

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pin_oe <= '0;
         pin_out <= '0;
      end else begin
         pin_oe <= next_pin_oe;
         pin_out <= next_pin_out;
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////////////
   // Pin levels and read-back

   pin_group_s pin_level;

   // Pins change with no regard to this clock
   pin_synchronizer #(
      .WIDTH($bits(pin_group_s))
   ) u_pin_sync (
      .clock(clock),
      .rst(rst),
      .async_in(pin_in),
      .sync_out(pin_level)
   );

   word_t vbus_dir_word;
   word_t sync_dir_word;
   word_t vbus_out_word;
   word_t sync_out_word;
   word_t vbus_in_word;
   word_t sync_in_word;
   assign vbus_dir_word = {video_out_dir, video_in_dir};
   assign sync_dir_word = {26'h0000000, sync_dir};
   assign vbus_out_word = {video_out_data, video_in_data};
   assign sync_out_word = {26'h0000000, sync_data};
   assign vbus_in_word = {pin_level.video_out_bus, pin_level.video_in_bus};
   assign sync_in_word = {26'h0000000, pin_level.sync};

   // Unmapped addresses read zero
   word_t next_rd_data;
   assign next_rd_data = !rd_en ? `READ_IDLE :
                         hit_vbus_dir ? vbus_dir_word :
                         hit_sync_dir ? sync_dir_word :
                         hit_vbus_out ? vbus_out_word :
                         hit_sync_out ? sync_out_word :
                         hit_vbus_in ? vbus_in_word :
                         hit_sync_in ? sync_in_word : `READ_IDLE;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rd_data <= `READ_IDLE;
      end else begin
         rd_data <= next_rd_data;
      end
   end

endmodule

// file: video_sync_gpio_direction_props.sv
`timescale 1ns/1ps
module video_sync_gpio_direction_props
   import video_sync_gpio_pkg::*;
#(
   parameter int ADDR_WIDTH = 12
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [ADDR_WIDTH-1:0] addr,
   input wire word_t wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire word_t rd_data,
   input wire pin_group_s gpio_select,
   input wire pin_group_s func_out,
   input wire pin_group_s func_oe,
   input wire pin_group_s pin_out,
   input wire pin_group_s pin_oe
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   // Shadows in pin order, so pins compare bit for bit
   logic [37:0] dir;
   logic [37:0] dat;
   wire [31:0] dir_hi = dir[37:6];
   wire [5:0] dir_lo = dir[5:0];
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         dir <= 38'h0;
         dat <= 38'h0;
      end else if (wr_en) begin
         if (addr == 12'h06C) dir[37:6] <= wr_data;
         if (addr == 12'h070) dir[5:0] <= wr_data[5:0];
         if (addr == 12'h100) dat[37:6] <= wr_data;
         if (addr == 12'h104) dat[5:0] <= wr_data[5:0];
      end
   end
   //////////////////////////////////////////////////////////////////////
   sequence s_dir_read;
      rd_en && addr == 12'h06C;
   endsequence
   sequence s_sync_read;
      rd_en && addr == 12'h070;
   endsequence
   chk_dir_readback: assert property (s_dir_read |=> rd_data == $past(dir_hi))
      else $error("direction word readback wrong");
   chk_sync_readback: assert property (s_sync_read |=> rd_data == {26'h0, $past(dir_lo)})
      else $error("sync direction readback wrong");
   chk_unmapped_zero: assert property (rd_en && addr == 12'h074 |=> rd_data == 32'h0)
      else $error("unmapped read not zero");
   chk_read_idle: assert property (!$past(rd_en) |-> rd_data == 32'h0)
      else $error("read data outside its cycle");
   // First edge after reset still shows reset levels
   chk_oe_gpio: assert property (!$past(rst) |->
      ((pin_oe ^ $past(dir)) & $past(gpio_select)) == 38'h0) else $error("gpio enable wrong");
   chk_oe_normal: assert property (!$past(rst) |->
      ((pin_oe ^ $past(func_oe)) & ~$past(gpio_select)) == 38'h0) else $error("normal oe wrong");
   chk_out_gpio: assert property (!$past(rst) |->
      ((pin_out ^ $past(dat)) & $past(gpio_select)) == 38'h0) else $error("gpio data wrong");
   chk_out_normal: assert property (!$past(rst) |->
      ((pin_out ^ $past(func_out)) & ~$past(gpio_select)) == 38'h0) else $error("normal data wrong");
endmodule
bind video_sync_gpio_direction video_sync_gpio_direction_props #(.ADDR_WIDTH(ADDR_WIDTH)) props (
   .clock(clock), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
   .rd_data(rd_data), .gpio_select(gpio_select), .func_out(func_out), .func_oe(func_oe),
   .pin_out(pin_out), .pin_oe(pin_oe)
);

// file: tb.sv
`timescale 1ns/1ps
`define CHK(g, e) \
   begin \
      total_checks++; \
      if ((g) !== (e)) begin \
         miscompares++; \
         $display("unexpected at %0t got %h exp %h", $time, (g), (e)); \
      end \
   end
module tb;
   import video_sync_gpio_pkg::*;
   logic clock = 0;
   logic rst = 1;
   logic [11:0] addr = 12'h000;
   word_t wr_data = 32'h0;
   logic wr_en = 0;
   logic rd_en = 0;
   word_t rd_data;
   pin_group_s gpio_select = '0, func_out = '0, func_oe = '0, pin_in = '0, pin_out, pin_oe;
   logic [37:0] m_dir = 38'h0;
   logic [37:0] m_dat = 38'h0;
   int miscompares = 0;
   int total_checks = 0;
   int i;
   video_sync_gpio_direction dut (.clock(clock), .rst(rst), .addr(addr), .wr_data(wr_data),
      .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .gpio_select(gpio_select),
      .func_out(func_out), .func_oe(func_oe), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
   initial begin
      forever #12.5 clock = ~clock;
   end
   //////////////////////////////////////////////////////////////////////
   function automatic logic [37:0] rnd38();
      return 38'({$urandom(), $urandom()});
   endfunction
   function automatic word_t exp_read(logic [11:0] a);
      case (a)
         12'h06C: return m_dir[37:6];
         12'h070: return {26'h0, m_dir[5:0]};
         12'h100: return m_dat[37:6];
         12'h104: return {26'h0, m_dat[5:0]};
         default: return 32'h0;
      endcase
   endfunction
   task bus(input logic w, input logic r, input logic [11:0] a, input word_t d);
      @(posedge clock);
      wr_en <= w;
      rd_en <= r;
      addr <= a;
      wr_data <= d;
   endtask
   task wr(input logic [11:0] a, input word_t d);
      bus(1, 0, a, d);
      case (a)
         12'h06C: m_dir[37:6] = d;
         12'h070: m_dir[5:0] = d[5:0];
         12'h100: m_dat[37:6] = d;
         12'h104: m_dat[5:0] = d[5:0];
         default: ;
      endcase
   endtask
   task rd(input logic [11:0] a);
      bus(0, 1, a, 32'h0);
      bus(0, 0, a, 32'h0);
      @(negedge clock);
      `CHK(rd_data, exp_read(a))
   endtask
   task pins(input logic [37:0] sel, input logic [37:0] fo, input logic [37:0] foe);
      bus(0, 0, 12'h000, 32'h0);
      gpio_select <= sel;
      func_out <= fo;
      func_oe <= foe;
      pin_in <= rnd38();
      @(posedge clock);
      @(negedge clock);
      `CHK(pin_oe, (sel & m_dir) | (~sel & foe))
      `CHK(pin_out, (sel & m_dat) | (~sel & fo))
   endtask
   task tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   initial begin
      i = $urandom(35);
      repeat (2) @(posedge clock);
      rst <= 0;
      rd(12'h06C);
      rd(12'h070);
      pins({38{1'b1}}, rnd38(), rnd38());
      // All ones: reserved sync bits must stay clear
      wr(12'h070, 32'hFFFFFFFF);
      rd(12'h070);
      wr(12'h06C, 32'hFFFFFFFF);
      pins({38{1'b1}}, rnd38(), rnd38());
      pins(38'h0, rnd38(), rnd38());
      wr(12'h074, 32'hFFFFFFFF);
      rd(12'h074);
      rd(12'h06C);
      for (i = 0; i < 40; i++) begin
         wr(12'h06C, $urandom());
         wr(12'h070, $urandom());
         wr(12'h100, $urandom());
         wr(12'h104, $urandom());
         rd(12'h06C);
         rd(12'h070);
         rd(12'h100);
         pins(rnd38(), rnd38(), rnd38());
      end
      bus(0, 0, 12'h000, 32'h0);
      rst <= 1;
      m_dir = 38'h0;
      m_dat = 38'h0;
      @(posedge clock);
      rst <= 0;
      rd(12'h06C);
      rd(12'h070);
      tally_and_finish;
   end
endmodule
